//--- rtl/fpi_pkg.sv
// Purpose: Shared constants for the flash page interface.
// Assumes: 40 MHz user clock, byte-addressed array organised in pages.
// Notes: Size codes, status bits, state codes and timing counts used by the control logic.
package fpi_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int PAGE_BYTES_LOG2 = 7;
  localparam int PAGE_BYTES = 1 << PAGE_BYTES_LOG2;
  localparam int PAGE_IDX_W = ADDR_W - PAGE_BYTES_LOG2;
  localparam int AUX_BYTES = 4;

  // Transfer size selector encodings
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;

  // Clock rate and operation times (ns)
  localparam int CLK_MHZ = 40;
  localparam int READ_TIME_NS = 50;
  localparam int PROG_TIME_NS = 200;
  localparam int READ_CYCLES = (READ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_CYCLES = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;

  // Page status word layout
  localparam int STAT_PROTECT_BIT = 0;
  localparam int STAT_DIRTY_BIT = 1;
  localparam int STAT_LOSS_ERR_BIT = 2;
  localparam int STAT_PROT_ERR_BIT = 3;

  localparam logic [7:0] ERASED_BYTE = 8'h00;

  typedef enum logic [2:0] {
    FPI_IDLE = 3'b000,
    FPI_READ = 3'b001,
    FPI_PROG = 3'b010,
    FPI_FLUSH = 3'b011,
    FPI_DONE = 3'b100
  } fpi_state_e;

endpackage : fpi_pkg

//--- rtl/fpi_flash_page_interface.sv
// Purpose: User-side control of a page-organised flash array with a page buffer.
// Assumes: Requester holds address and width stable until busy rises.
// Notes: The array is a behavioural storage array; timing is in cycles.
//
// How it works
// RULE1: Eighteen-bit byte address selects array location.
// RULE2: Aux select routes access to aux block.
// RULE3: Busy held high while operation runs.
// RULE4: Everything sampled on rising clock edge.
// RULE5: Width code picks one, two, four bytes.
// RULE6: Drop input empties the page buffer.
// RULE7: Clear writes addressed page to zeros.
// RULE8: Fabric raises ownership request to claim array.
// RULE9: Replace only overwrites pages not protected.
// RULE10: Protect input marks programmed pages protected.
// RULE11: Status select with read gives status.
// RULE12: Guard blocks page switch while buffer dirty.
// RULE13: Pipe input adds read data register.
// RULE14: Program writes buffer into addressed page.
// RULE15: Read data valid first non-busy cycle.
// RULE16: Sequential select with read reads next.
// RULE17: Read alone reads address and width.
// RULE18: Low reset returns interface to idle.
// RULE19: Sector extra page select routes access.
// RULE20: Requester strobes only while busy low.
`timescale 1ns/1ps
module fpi_flash_page_interface
  import fpi_pkg::*;
#(
  parameter int NUM_PAGES = 64,
  parameter int SECTOR_PAGES = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clockEnable,
  input wire logic resetN,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [1:0] transferSizeSel,
  input wire logic [DATA_W-1:0] writeData,
  input wire logic writeEnable,
  input wire logic readEnable,
  input wire logic sequentialReadSel,
  input wire logic statusReadSel,
  input wire logic auxAreaSelect,
  input wire logic sectorExtraPageSel,
  input wire logic bufferDrop,
  input wire logic pageClear,
  input wire logic pageReplace,
  input wire logic programReq,
  input wire logic protectOnProgram,
  input wire logic dirtyBufferGuard,
  input wire logic pipeSel,
  input wire logic fabricOwnershipReq,
  output logic busy,
  output logic [DATA_W-1:0] readData,
  output logic fabricOwns
);

  localparam int PIDX_W = $clog2(NUM_PAGES + 1);
  localparam int CNT_W = 8;
  localparam int SPARE_PAGE = NUM_PAGES;
  localparam int PAGE_STORE = NUM_PAGES + 1;

  // Main storage plus one shared spare page; aux bytes per page
  logic [7:0] mainMem [PAGE_STORE][PAGE_BYTES];
  logic [7:0] auxMem [PAGE_STORE][AUX_BYTES];
  logic protect_reg [PAGE_STORE];
  logic [7:0] pageBuf [PAGE_BYTES];

  fpi_state_e state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [PIDX_W-1:0] curPage;
  logic [PIDX_W-1:0] bufPage_reg;
  logic bufDirty_reg;
  logic bufValid_reg;
  logic [ADDR_W-1:0] opAddr_reg;
  logic [1:0] opSize_reg;
  logic opAux_reg;
  logic opStatus_reg;
  logic opClear_reg;
  logic opProtect_reg;
  logic lossErr_reg;
  logic protErr_reg;
  logic [DATA_W-1:0] rdWord_reg;
  logic [DATA_W-1:0] rdPipe_reg;
  logic pipe_reg;
  logic nvmRst;
  logic [ADDR_W-1:0] seqAddr;
  logic [PIDX_W-1:0] opPage_reg;
  logic [PAGE_BYTES_LOG2-1:0] opOff;
  logic [DATA_W-1:0] fetch;
  logic pageSwitch;
  logic anyCmd;
  logic [2:0] nBytes;

  ////////////////////////////////////////////////////////////////////////////
  // RULE18: reset combine
  assign nvmRst = srst || !resetN;

  // RULE1: page and offset
  // RULE19: spare page route
  function automatic logic [PIDX_W-1:0] pageOf(input logic [ADDR_W-1:0] a, input logic spare);
    logic [PAGE_IDX_W-1:0] p;
    p = a[ADDR_W-1:PAGE_BYTES_LOG2];
    if (spare) begin
      pageOf = PIDX_W'(SPARE_PAGE);
    end else begin
      pageOf = PIDX_W'(p % PAGE_IDX_W'(NUM_PAGES));
    end
  endfunction : pageOf

  // Read-next continues from the byte after the last read
  assign seqAddr = opAddr_reg + ADDR_W'(nBytes);
  assign curPage = pageOf(address, sectorExtraPageSel);
  assign opOff = opAddr_reg[PAGE_BYTES_LOG2-1:0];
  assign anyCmd = readEnable || writeEnable || programReq || pageClear || pageReplace;
  // RULE12: dirty guard check
  assign pageSwitch = dirtyBufferGuard && bufDirty_reg && (curPage != bufPage_reg);

  // RULE5: width decode
  always_comb begin
    if (opSize_reg == SIZE_BYTE) begin
      nBytes = 3'd1;
    end else if (opSize_reg == SIZE_HALF) begin
      nBytes = 3'd2;
    end else begin
      nBytes = 3'd4;
    end
  end

  // RULE2: aux or main fetch
  always_comb begin
    fetch = '0;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(nBytes)) begin
        if (opAux_reg) begin
          fetch[i*8 +: 8] = auxMem[opPage_reg][(int'(opOff) + i) % AUX_BYTES];
        end else if (bufValid_reg && opPage_reg == bufPage_reg) begin
          // A read of the buffered page sees writes not yet committed
          fetch[i*8 +: 8] = pageBuf[PAGE_BYTES_LOG2'(int'(opOff) + i)];
        end else begin
          fetch[i*8 +: 8] = mainMem[opPage_reg][PAGE_BYTES_LOG2'(int'(opOff) + i)];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE3: busy sequencing
  // RULE4: rising edge only
  // RULE20: commands only when idle
  always_ff @(posedge clock) begin
    if (nvmRst) begin
      state_reg <= FPI_IDLE;
      cnt_reg <= '0;
      busy <= 1'b0;
      opAddr_reg <= '0;
      opSize_reg <= 2'h0;
      opAux_reg <= 1'b0;
      opStatus_reg <= 1'b0;
      opClear_reg <= 1'b0;
      opProtect_reg <= 1'b0;
      bufPage_reg <= '0;
      opPage_reg <= '0;
    end else if (clockEnable) begin
      unique case (state_reg)
        FPI_IDLE: begin
          if (anyCmd && pageSwitch) begin
            // Refused: the error flag process records it, state stays idle
            state_reg <= FPI_IDLE;
          end else if (readEnable) begin
            // RULE16: read next
            // RULE17: plain read
            opAddr_reg <= sequentialReadSel ? seqAddr : address;
            opSize_reg <= transferSizeSel;
            opAux_reg <= auxAreaSelect;
            // RULE11: status read
            opStatus_reg <= statusReadSel;
            opPage_reg <= sequentialReadSel ? opPage_reg : curPage;
            cnt_reg <= CNT_W'(READ_CYCLES);
            busy <= 1'b1;
            state_reg <= FPI_READ;
          end else if (programReq || pageClear || pageReplace) begin
            bufPage_reg <= curPage;
            opAux_reg <= auxAreaSelect;
            // RULE7: clear to zeros
            opClear_reg <= pageClear;
            // RULE10: protect on program
            opProtect_reg <= protectOnProgram;
            cnt_reg <= CNT_W'(PROG_CYCLES);
            busy <= 1'b1;
            state_reg <= FPI_PROG;
          end else if (writeEnable) begin
            // The buffer now belongs to this page; the guard compares against it
            bufPage_reg <= curPage;
          end
        end
        FPI_READ, FPI_PROG: begin
          if (cnt_reg <= CNT_W'(1)) begin
            state_reg <= state_reg == FPI_READ ? FPI_DONE : FPI_FLUSH;
          end else begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end
        end
        FPI_FLUSH: begin
          state_reg <= FPI_DONE;
        end
        FPI_DONE: begin
          busy <= 1'b0;
          state_reg <= FPI_IDLE;
        end
        default: begin
          state_reg <= FPI_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer: loaded by writes, emptied by drop or after programming
  always_ff @(posedge clock) begin
    if (nvmRst) begin
      bufDirty_reg <= 1'b0;
      bufValid_reg <= 1'b0;
    end else if (clockEnable) begin
      if (state_reg == FPI_IDLE && writeEnable && !pageSwitch && !readEnable) begin
        if (!bufValid_reg || curPage != bufPage_reg) begin
          for (int i = 0; i < PAGE_BYTES; i++) begin
            pageBuf[i] <= mainMem[curPage][i];
          end
        end
        for (int i = 0; i < 4; i++) begin
          if (i < (transferSizeSel == SIZE_BYTE ? 1 : (transferSizeSel == SIZE_HALF ? 2 : 4))) begin
            pageBuf[PAGE_BYTES_LOG2'(int'(address[PAGE_BYTES_LOG2-1:0]) + i)] <=
              writeData[i*8 +: 8];
          end
        end
        bufValid_reg <= 1'b1;
        bufDirty_reg <= 1'b1;
      end else if (state_reg == FPI_FLUSH) begin
        bufDirty_reg <= 1'b0;
        bufValid_reg <= 1'b0;
      // RULE6: drop buffer
      end else if (state_reg == FPI_IDLE && bufferDrop) begin
        bufDirty_reg <= 1'b0;
        bufValid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE12: loss error flag
  // Both flags stick until the next program-class command, so software
  // can read the cause of a refusal afterwards with a status read
  always_ff @(posedge clock) begin
    if (nvmRst) begin
      lossErr_reg <= 1'b0;
      protErr_reg <= 1'b0;
    end else if (clockEnable && state_reg == FPI_IDLE) begin
      if (anyCmd && pageSwitch) begin
        lossErr_reg <= 1'b1;
      end else if (!readEnable && (programReq || pageClear || pageReplace)) begin
        lossErr_reg <= 1'b0;
        protErr_reg <= 1'b0;
      end
    end else if (clockEnable && state_reg == FPI_FLUSH) begin
      // RULE9: protected page refusal
      if (protect_reg[bufPage_reg]) begin
        protErr_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array commit at the end of a program-class operation
  always_ff @(posedge clock) begin
    if (nvmRst) begin
      for (int p = 0; p < PAGE_STORE; p++) begin
        protect_reg[p] <= 1'b0;
      end
    end else if (clockEnable && state_reg == FPI_FLUSH) begin
      // RULE9: replace if writable
      if (!protect_reg[bufPage_reg]) begin
        // RULE14: program page
        // RULE2: aux block program
        // An aux program leaves main storage alone and takes the low buffer bytes
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (opClear_reg) begin
            mainMem[bufPage_reg][i] <= ERASED_BYTE;
          end else if (bufValid_reg && !opAux_reg) begin
            mainMem[bufPage_reg][i] <= pageBuf[i];
          end
        end
        for (int i = 0; i < AUX_BYTES; i++) begin
          if (opClear_reg) begin
            auxMem[bufPage_reg][i] <= ERASED_BYTE;
          end else if (bufValid_reg && opAux_reg) begin
            auxMem[bufPage_reg][i] <= pageBuf[i];
          end
        end
        if (opProtect_reg) begin
          protect_reg[bufPage_reg] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE15: data on done
  always_ff @(posedge clock) begin
    if (nvmRst) begin
      rdWord_reg <= '0;
      rdPipe_reg <= '0;
      pipe_reg <= 1'b0;
      readData <= '0;
    end else if (clockEnable) begin
      pipe_reg <= pipeSel;
      if (state_reg == FPI_READ && cnt_reg <= CNT_W'(1)) begin
        if (opStatus_reg) begin
          rdWord_reg <= '0;
          rdWord_reg[STAT_PROTECT_BIT] <= protect_reg[opPage_reg];
          rdWord_reg[STAT_DIRTY_BIT] <= bufDirty_reg;
          rdWord_reg[STAT_LOSS_ERR_BIT] <= lossErr_reg;
          rdWord_reg[STAT_PROT_ERR_BIT] <= protErr_reg;
        end else begin
          rdWord_reg <= fetch;
        end
      end
      rdPipe_reg <= rdWord_reg;
      // RULE13: optional pipe stage
      readData <= pipe_reg ? rdPipe_reg : rdWord_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE8: ownership flag
  // Registered echo only; arbitration with the test port lies outside
  always_ff @(posedge clock) begin
    if (nvmRst) begin
      fabricOwns <= 1'b0;
    end else if (clockEnable) begin
      fabricOwns <= fabricOwnershipReq;
    end
  end

endmodule : fpi_flash_page_interface

//--- testbench/fpi_chk.sv
// Purpose: Port checks of the flash page interface.
// Assumes: One clock; srst or low resetN resets.
// Notes: Busy lengths are the read count plus one and the program count plus two.
`timescale 1ns/1ps
module fpi_chk
  import fpi_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic resetN,
  input wire logic clockEnable,
  input wire logic writeEnable,
  input wire logic readEnable,
  input wire logic bufferDrop,
  input wire logic pageClear,
  input wire logic pageReplace,
  input wire logic programReq,
  input wire logic dirtyBufferGuard,
  input wire logic fabricOwnershipReq,
  input wire logic busy,
  input wire logic [DATA_W-1:0] readData,
  input wire logic fabricOwns
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst || !resetN);
  // Guarded commands may be refused, so they are left out
  sequence s_quiet;
    !busy [*3];
  endsequence
  sequence s_read;
    s_quiet ##0 (clockEnable && readEnable && !dirtyBufferGuard);
  endsequence
  sequence s_prog;
    s_quiet ##0 (clockEnable && !readEnable && !dirtyBufferGuard && (programReq || pageClear));
  endsequence
  sequence s_nop;
    s_quiet ##0 (clockEnable && (writeEnable || bufferDrop) && !readEnable && !programReq
      && !pageClear && !pageReplace);
  endsequence
  a_read_busy_len: assert property (s_read |-> ##1 busy [*3] ##1 !busy)
    else $error("read busy length wrong");
  a_prog_busy_len: assert property (s_prog |-> ##1 busy [*8] ##1 busy [*2] ##1 !busy)
    else $error("program busy length wrong");
  a_buffer_no_busy: assert property (s_nop |-> ##2 !busy)
    else $error("buffer op raised busy");
  a_busy_min_len: assert property ($rose(busy) |-> busy [*3])
    else $error("busy too short");
  a_busy_has_cause: assert property ($rose(busy) |-> $past(readEnable || programReq
    || pageClear || pageReplace, 1))
    else $error("busy without command");
  a_reset_quiet: assert property (disable iff (1'b0) (srst || !resetN) |=> !busy
    && readData == '0 && !fabricOwns)
    else $error("outputs not cleared by reset");
  a_owns_echo: assert property (clockEnable |=> fabricOwns == $past(fabricOwnershipReq))
    else $error("ownership not echoed");
  a_data_hold: assert property (busy && $past(busy) |-> $stable(readData))
    else $error("read data moved while busy");
endmodule : fpi_chk
////////////////////////////////////////
bind fpi_flash_page_interface fpi_chk fpi_chk_i (.clock(clock), .srst(srst), .resetN(resetN),
  .clockEnable(clockEnable), .writeEnable(writeEnable), .readEnable(readEnable),
  .bufferDrop(bufferDrop), .pageClear(pageClear), .pageReplace(pageReplace),
  .programReq(programReq), .dirtyBufferGuard(dirtyBufferGuard),
  .fabricOwnershipReq(fabricOwnershipReq), .busy(busy), .readData(readData),
  .fabricOwns(fabricOwns));

//--- testbench/fpi_fabric_model.sv
// Purpose: Fabric-side requester beside the interface.
// Assumes: Bench strobes only while mayIssue is high.
// Notes: Ownership request follows claim one clock later.
`timescale 1ns/1ps
module fpi_fabric_model (
  input wire logic clock,
  input wire logic busy,
  input wire logic claim,
  output logic fabricOwnershipReq,
  output logic mayIssue
);
  initial fabricOwnershipReq = 1'b0;
  always @(posedge clock) begin
    fabricOwnershipReq <= claim;
  end
  assign mayIssue = !busy;
endmodule : fpi_fabric_model

//--- testbench/tb_top.sv
// Purpose: Self-checking bench of the flash page interface.
// Assumes: Default page count; clockEnable low only in the freeze scenario.
// Notes: Each op waits for busy to drop, then reads twice.
`timescale 1ns/1ps
module tb_top;
  import fpi_pkg::*;
  localparam logic [9:0] WE = 10'h200, RE = 10'h100, SQ = 10'h080, ST = 10'h040;
  localparam logic [9:0] AX = 10'h020, SP = 10'h010, DR = 10'h008, CL = 10'h004;
  localparam logic [9:0] RP = 10'h002, PG = 10'h001;
  logic clock = 1'b0, srst = 1'b1, resetN = 1'b1, pipeSel = 1'b0, prot = 1'b0;
  logic guard = 1'b0, claim = 1'b0, rose = 1'b0, mayIssue, fabricOwnershipReq, busy, fabricOwns;
  logic ce = 1'b1;
  logic [9:0] s = '0;
  logic [ADDR_W-1:0] address = '0;
  logic [1:0] size = '0;
  logic [DATA_W-1:0] wd = '0, readData, rd, rd0;
  int failures = 0, compares = 0, cycles = 0;
  always #12.5 clock = ~clock;
  fpi_flash_page_interface fpi_flash_page_interface_i (
    .clock(clock), .srst(srst), .clockEnable(ce), .resetN(resetN), .address(address),
    .transferSizeSel(size), .writeData(wd), .writeEnable(s[9]), .readEnable(s[8]),
    .sequentialReadSel(s[7]), .statusReadSel(s[6]), .auxAreaSelect(s[5]),
    .sectorExtraPageSel(s[4]), .bufferDrop(s[3]), .pageClear(s[2]), .pageReplace(s[1]),
    .programReq(s[0]), .protectOnProgram(prot), .dirtyBufferGuard(guard), .pipeSel(pipeSel),
    .fabricOwnershipReq(fabricOwnershipReq), .busy(busy), .readData(readData),
    .fabricOwns(fabricOwns));
  fpi_fabric_model fpi_fabric_model_i (.clock(clock), .busy(busy), .claim(claim),
    .fabricOwnershipReq(fabricOwnershipReq), .mayIssue(mayIssue));
  ////////////////////////////////////////
  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic op(input logic [9:0] c, input logic [ADDR_W-1:0] a, input logic [1:0] w,
      input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    repeat (2) @(negedge clock);
    while (mayIssue !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    s <= c;
    address <= a;
    size <= w;
    wd <= d;
    @(posedge clock);
    s <= '0;
    rose = 1'b0;
    @(posedge clock);
    #1;
    while (busy === 1'b1 && n < 60) begin
      rose = 1'b1;
      @(posedge clock);
      #1;
      n++;
    end
    rd0 = readData;
    @(posedge clock);
    #1;
    rd = readData;
  endtask : op
  task automatic t_rw;
    op(WE, 18'h00080, 2'h2, 32'h44332211);
    op(PG, 18'h00080, 2'h0, '0);
    op(RE, 18'h00080, 2'h2, '0);
    chk("word", rd, 32'h44332211);
    chk("first", rd0, 32'h44332211);
    op(RE, 18'h00080, 2'h0, '0);
    chk("byte", rd & 32'hff, 32'h11);
    op(RE | SQ, 18'h00080, 2'h0, '0);
    chk("next", rd & 32'hff, 32'h22);
    op(RE, 18'h00082, 2'h1, '0);
    chk("half", rd & 32'hffff, 32'h4433);
  endtask : t_rw
  task automatic t_clear;
    op(CL, 18'h00080, 2'h0, '0);
    op(RE, 18'h00080, 2'h3, '0);
    chk("clear", rd, {4{ERASED_BYTE}});
  endtask : t_clear
  task automatic t_protect;
    @(posedge clock);
    prot <= 1'b1;
    op(WE, 18'h00100, 2'h2, 32'ha5a5a5a5);
    op(PG, 18'h00100, 2'h2, '0);
    prot <= 1'b0;
    op(RE | ST, 18'h00100, 2'h2, '0);
    chk("prot", rd & 32'h1, 32'h1);
    op(WE, 18'h00100, 2'h2, 32'h0f0f0f0f);
    op(RP, 18'h00100, 2'h2, '0);
    op(RE, 18'h00100, 2'h2, '0);
    chk("kept", rd, 32'ha5a5a5a5);
    op(DR, 18'h00180, 2'h2, '0);
    op(WE, 18'h00180, 2'h2, 32'h0f0f0f0f);
    op(RP, 18'h00180, 2'h2, '0);
    op(RE, 18'h00180, 2'h2, '0);
    chk("replace", rd, 32'h0f0f0f0f);
  endtask : t_protect
  task automatic t_guard;
    @(posedge clock);
    guard <= 1'b1;
    op(WE, 18'h00200, 2'h2, 32'h12345678);
    op(RE, 18'h00280, 2'h2, '0);
    chk("refuse", {31'h0, rose}, 32'h0);
    op(RE | ST, 18'h00200, 2'h2, '0);
    chk("loss", rd & 32'h6, 32'h6);
    op(DR, 18'h00200, 2'h2, '0);
    op(RE | ST, 18'h00200, 2'h2, '0);
    chk("drop", rd & 32'h2, 32'h0);
    guard <= 1'b0;
  endtask : t_guard
  task automatic t_area;
    logic [9:0] sel [2];
    sel = '{AX, SP};
    foreach (sel[i]) begin
      op(CL, 18'h00300, 2'h2, '0);
      op(WE, 18'h00300, 2'h2, 32'hc3c3c3c3);
      op(PG | sel[i], 18'h00300, 2'h2, '0);
      op(RE | sel[i], 18'h00300, 2'h2, '0);
      chk("area", rd, 32'hc3c3c3c3);
      op(RE, 18'h00300, 2'h2, '0);
      chk("main", rd, {4{ERASED_BYTE}});
    end
  endtask : t_area
  task automatic t_pipe;
    @(posedge clock);
    pipeSel <= 1'b1;
    op(RE | SP, 18'h00300, 2'h2, '0);
    chk("early", rd0, {4{ERASED_BYTE}});
    chk("piped", rd, 32'hc3c3c3c3);
    pipeSel <= 1'b0;
  endtask : t_pipe
  // A read strobe held while frozen must not start anything
  task automatic t_freeze;
    @(posedge clock);
    ce <= 1'b0;
    s <= RE;
    address <= 18'h00080;
    repeat (3) @(posedge clock);
    s <= '0;
    #1;
    chk("freeze", {31'h0, busy}, 32'h0);
    ce <= 1'b1;
  endtask : t_freeze
  task automatic t_reset;
    @(posedge clock);
    claim <= 1'b1;
    s <= RE;
    @(posedge clock);
    s <= '0;
    repeat (2) @(posedge clock);
    resetN <= 1'b0;
    @(posedge clock);
    resetN <= 1'b1;
    #1;
    chk("reset", readData | {30'h0, busy, fabricOwns}, '0);
    op(RE, 18'h00080, 2'h2, '0);
    chk("owns", {31'h0, rose & fabricOwns}, 32'h1);
  endtask : t_reset
  // Ceiling well above the few hundred ops cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    t_rw();
    t_clear();
    t_protect();
    t_guard();
    t_area();
    t_pipe();
    t_freeze();
    t_reset();
    conclude();
  end
endmodule : tb_top
